// File: hw/sprt_pkg.sv
// package of constants and enumerations for the serial port block
// assumes a single core clock; no register bus, control bits are ports
// What this block does
// - async receiver detects start, shifts, checks frame
// - full flag set at frame end gives overrun
// - parity mismatch flags error, still delivers data
// - stop bit low flags framing, delivers data
// - clean character delivered, full flag set, irq
// - errored character leaves full flag unchanged
// - reception halts while any error flag set
// - overrun discards data, all detected flags set
// - reading data clears the full flag
// - sync character is eight bits, lsb first
// - drive on falling edge, sample on rising
// - transmit line holds msb after last bit
// - internal clock gives eight pulses, idles high
// - clock source chosen by mode and enables
// - pending data loaded, empty flag set, irq
// - at bit seven pending data continues seamlessly
// - nothing pending sets end flag, holds levels
// - transmit start blocked while error flags set
// - sync overrun keeps full flag, discards data
// - double-buffered transmit and receive, tx start gated by rx error flags
// - async frame start, data, parity, stop
// - sixteen base ticks per bit, sample eighth
package sprt_pkg;

  localparam int unsigned DATA_BITS     = 8;
  localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;
  localparam logic [3:0]  SAMPLE_TICK   = 4'h7;
  localparam logic [7:0]  RST_DATA      = 8'h00;
  localparam logic        RST_TX_EMPTY  = 1'b1;
  localparam logic        RST_TX_END    = 1'b1;
  localparam logic        RST_LINE      = 1'b1;

  typedef enum logic [3:0] {
    SPRT_A_IDLE  = 4'h1,
    SPRT_A_START = 4'h2,
    SPRT_A_DATA  = 4'h4,
    SPRT_A_STOP  = 4'h8
  } sprt_arx_t;

endpackage : sprt_pkg

// File: hw/sprt_serial_port.sv
// serial port: asynchronous receiver plus clocked synchronous
// transmitter and receiver, with status flags and request levels
// assumes pins and control inputs are synchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none

module sprt_serial_port
  import sprt_pkg::*;
#(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic             i_core_clk,          // core clock
  input  wire logic             i_arst_n,            // async reset
  input  wire logic             i_sync_mode,         // 1 clocked sync
  input  wire logic             i_clk_enable_hi,     // 1 external clock
  input  wire logic             i_rx_enable,         // receiver on
  input  wire logic             i_tx_enable,         // transmitter on
  input  wire logic             i_parity_en,         // async parity on
  input  wire logic             i_parity_odd,        // 1 odd parity
  input  wire logic             i_rx_irq_enable,     // rx requests on
  input  wire logic             i_tx_irq_enable,     // tx empty req on
  input  wire logic             i_tx_end_irq_enable, // tx end req on
  input  wire logic [DIV_W-1:0] i_baud_div,          // tick period - 1
  input  wire logic             i_rxd,               // receive line
  input  wire logic             i_sck,               // serial clk pin in
  input  wire logic             i_tx_wr,             // write tx data
  input  wire logic [7:0]       i_tx_data,           // tx data
  input  wire logic             i_rx_rd,             // read rx data
  input  wire logic             i_clr_overrun,       // clear overrun
  input  wire logic             i_clr_framing,       // clear framing
  input  wire logic             i_clr_parity,        // clear parity
  input  wire logic             i_clr_rx_full,       // clear rx full
  output logic                  o_txd,               // transmit line
  output logic                  o_sck,               // serial clk out
  output logic                  o_sck_oe,            // serial clk drive
  output logic [7:0]            o_rx_data,           // rx data reg
  output logic                  o_rx_full_flag,      // rx full
  output logic                  o_overrun_flag,      // overrun
  output logic                  o_framing_err_flag,  // framing error
  output logic                  o_parity_err_flag,   // parity error
  output logic                  o_tx_empty_flag,     // tx data empty
  output logic                  o_tx_end_flag,       // tx ended
  output logic                  o_rx_full_irq,       // rx full request
  output logic                  o_rx_error_irq,      // error request
  output logic                  o_tx_empty_irq,      // tx empty request
  output logic                  o_tx_end_irq         // tx end request
);

  if (DIV_W < 1 || DIV_W > 24) begin : g_bad_div
    $error("DIV_W must lie between 1 and 24");
  end

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic             sck_prev;
    logic             rxd_prev;
    logic             sck_out;
    logic             sck_oe;
    sprt_arx_t        ast;
    logic [3:0]       acnt;
    logic [2:0]       abit;
    logic [7:0]       arsr;
    logic             apar;
    logic             apar_due;
    logic [7:0]       tx_data_reg;
    logic [7:0]       tx_shift_reg;
    logic             txd;
    logic             tx_active;
    logic             tx_last;
    logic [2:0]       tcnt;
    logic [7:0]       srsr;
    logic [2:0]       scnt;
    logic [7:0]       rx_data_reg;
    logic             rx_full;
    logic             ovr;
    logic             fe;
    logic             pe;
    logic             tx_empty;
    logic             tx_end;
    logic             irq_rxf;
    logic             irq_err;
    logic             irq_txe;
    logic             irq_tx_end_flag;
  } sprt_state_t;

  sprt_state_t st_reg;
  sprt_state_t st_next;

  // character completion shared by both receive modes
  function automatic sprt_state_t sprt_rx_done(
    input sprt_state_t s,
    input logic [7:0]  d,
    input logic        f,
    input logic        p
  );
    sprt_state_t t;
    t = s;
    t.fe = s.fe | f;
    t.pe = s.pe | p;
    if (s.rx_full) begin
      t.ovr = 1'b1;
    end else begin
      t.rx_data_reg = d;
      if (!(f | p)) begin
        t.rx_full = 1'b1;
      end
    end
    return t;
  endfunction : sprt_rx_done

  logic       err_any;
  logic       internal_clk;
  logic       tick;
  logic       base_tick;
  logic       ext_rise;
  logic       ext_fall;
  logic       tx_start_ok;
  logic       want_clk;
  logic       fall;
  logic       rise;
  logic [7:0] rx_word;
  logic       par_bad;

  always_comb begin
    st_next      = st_reg;
    err_any      = st_reg.ovr | st_reg.fe | st_reg.pe;
    internal_clk = !i_clk_enable_hi;
    tick         = (st_reg.div_cnt == i_baud_div);
    ext_rise     = i_sck & !st_reg.sck_prev;
    ext_fall     = !i_sck & st_reg.sck_prev;
    base_tick    = internal_clk ? tick : ext_rise;
    rx_word      = 8'h00;
    par_bad      = 1'b0;

    st_next.div_cnt  = tick ? '0 : DIV_W'(st_reg.div_cnt + 1'b1);
    st_next.sck_prev = i_sck;
    st_next.rxd_prev = i_rxd;

    // software clears go first so a same-cycle hardware set wins
    if (i_rx_rd || i_clr_rx_full) begin
      st_next.rx_full = 1'b0;
    end
    if (i_clr_overrun) begin
      st_next.ovr = 1'b0;
    end
    if (i_clr_framing) begin
      st_next.fe = 1'b0;
    end
    if (i_clr_parity) begin
      st_next.pe = 1'b0;
    end

    // synchronous clock: internal one only runs while work is wanted
    tx_start_ok = i_tx_enable && !st_reg.tx_empty && !err_any
                  && !st_reg.tx_active;
    want_clk    = (st_reg.tx_active && !st_reg.tx_last) || tx_start_ok
                  || (i_rx_enable && !i_tx_enable && !err_any);
    fall = i_sync_mode
           && (internal_clk ? (tick && st_reg.sck_out && want_clk)
                            : ext_fall);
    rise = i_sync_mode
           && (internal_clk ? (tick && !st_reg.sck_out) : ext_rise);

    // a pulse, once begun, always completes, so the pin rests high
    st_next.sck_oe = i_sync_mode && internal_clk;
    if (!st_next.sck_oe || rise) begin
      st_next.sck_out = 1'b1;
    end else if (fall) begin
      st_next.sck_out = 1'b0;
    end

    // synchronous transmitter, shifting on falling edges
    if (!i_tx_enable || !i_sync_mode) begin
      st_next.tx_active = 1'b0;
      st_next.tx_last   = 1'b0;
      st_next.tcnt      = 3'h0;
      if (!i_tx_enable) begin
        st_next.tx_empty = 1'b1;
      end
      if (!i_sync_mode) begin
        st_next.txd = RST_LINE;
      end
    end else begin
      if (fall && tx_start_ok) begin
        st_next.txd          = st_reg.tx_data_reg[0];
        st_next.tx_shift_reg = {1'b0, st_reg.tx_data_reg[7:1]};
        st_next.tx_empty     = 1'b1;
        st_next.tx_end       = 1'b0;
        st_next.tx_active    = 1'b1;
        st_next.tcnt         = 3'h0;
      end else if (fall && st_reg.tx_active && !st_reg.tx_last) begin
        st_next.txd          = st_reg.tx_shift_reg[0];
        st_next.tx_shift_reg = {1'b0, st_reg.tx_shift_reg[7:1]};
        st_next.tcnt         = 3'(st_reg.tcnt + 1'b1);
        if (st_next.tcnt == LAST_BIT_IDX) begin
          // the msb now sits in txd, so the shifter is free
          if (!st_reg.tx_empty && !err_any) begin
            st_next.tx_shift_reg = st_reg.tx_data_reg;
            st_next.tx_empty     = 1'b1;
          end else begin
            st_next.tx_last = 1'b1;
            st_next.tx_end  = 1'b1;
          end
        end
      end
      if (rise && st_reg.tx_last) begin
        // txd is left alone: the line keeps the msb level
        st_next.tx_active = 1'b0;
        st_next.tx_last   = 1'b0;
      end
    end

    if (i_tx_wr) begin
      st_next.tx_data_reg = i_tx_data;
      st_next.tx_empty    = 1'b0;
    end

    // synchronous receiver, sampling on rising edges
    if (!i_rx_enable || !i_sync_mode) begin
      st_next.scnt = 3'h0;
    end else if (rise && !err_any) begin
      rx_word      = {i_rxd, st_reg.srsr[7:1]};
      st_next.srsr = rx_word;
      st_next.scnt = 3'(st_reg.scnt + 1'b1);
      if (st_reg.scnt == LAST_BIT_IDX) begin
        st_next = sprt_rx_done(st_next, rx_word, 1'b0, 1'b0);
      end
    end

    // asynchronous receiver on a sixteen-times base tick
    if (!i_rx_enable || i_sync_mode || err_any) begin
      st_next.ast = SPRT_A_IDLE;
    end else begin
      unique case (st_reg.ast)
        SPRT_A_IDLE: begin
          if (st_reg.rxd_prev && !i_rxd) begin
            st_next.ast  = SPRT_A_START;
            st_next.acnt = 4'h0;
          end
        end
        SPRT_A_START, SPRT_A_DATA, SPRT_A_STOP: begin
          if (base_tick) begin
            st_next.acnt = 4'(st_reg.acnt + 1'b1);
          end
          if (base_tick && st_reg.acnt == SAMPLE_TICK) begin
            unique case (st_reg.ast)
              SPRT_A_START: begin
                // a short glitch low is not a start bit
                st_next.ast  = i_rxd ? SPRT_A_IDLE : SPRT_A_DATA;
                st_next.abit = 3'h0;
                st_next.apar_due = 1'b0;
              end
              SPRT_A_DATA: begin
                if (st_reg.abit == LAST_BIT_IDX && st_reg.apar_due) begin
                  st_next.apar     = i_rxd;
                  st_next.apar_due = 1'b0;
                  st_next.ast      = SPRT_A_STOP;
                end else if (st_reg.abit == LAST_BIT_IDX) begin
                  // the msb is kept first; the parity sample comes next
                  st_next.arsr     = {i_rxd, st_reg.arsr[7:1]};
                  st_next.apar_due = i_parity_en;
                  st_next.ast  = i_parity_en ? SPRT_A_DATA : SPRT_A_STOP;
                end else begin
                  st_next.arsr = {i_rxd, st_reg.arsr[7:1]};
                  st_next.abit = 3'(st_reg.abit + 1'b1);
                end
              end
              default: begin
                // first stop bit decides framing; extra ones idle high
                par_bad = st_reg.apar_due ? 1'b0 :
                          ((^st_reg.arsr ^ st_reg.apar) != i_parity_odd)
                          && i_parity_en;
                st_next = sprt_rx_done(st_next, st_reg.arsr, !i_rxd,
                                       par_bad);
                st_next.ast = SPRT_A_IDLE;
              end
            endcase
          end
        end
        default: begin
          st_next.ast = SPRT_A_IDLE;
        end
      endcase
    end

    st_next.irq_rxf  = i_rx_irq_enable && st_next.rx_full;
    st_next.irq_err  = i_rx_irq_enable
                       && (st_next.ovr || st_next.fe || st_next.pe);
    st_next.irq_txe  = i_tx_irq_enable && st_next.tx_empty;
    st_next.irq_tx_end_flag = i_tx_end_irq_enable && st_next.tx_end;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg              <= '0;
      st_reg.sck_prev     <= RST_LINE;
      st_reg.rxd_prev     <= RST_LINE;
      st_reg.sck_out      <= RST_LINE;
      st_reg.ast          <= SPRT_A_IDLE;
      st_reg.txd          <= RST_LINE;
      st_reg.tx_data_reg  <= RST_DATA;
      st_reg.rx_data_reg  <= RST_DATA;
      st_reg.tx_empty     <= RST_TX_EMPTY;
      st_reg.tx_end       <= RST_TX_END;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_txd              = st_reg.txd;
  assign o_sck              = st_reg.sck_out;
  assign o_sck_oe           = st_reg.sck_oe;
  assign o_rx_data          = st_reg.rx_data_reg;
  assign o_rx_full_flag     = st_reg.rx_full;
  assign o_overrun_flag     = st_reg.ovr;
  assign o_framing_err_flag = st_reg.fe;
  assign o_parity_err_flag  = st_reg.pe;
  assign o_tx_empty_flag    = st_reg.tx_empty;
  assign o_tx_end_flag      = st_reg.tx_end;
  assign o_rx_full_irq      = st_reg.irq_rxf;
  assign o_rx_error_irq     = st_reg.irq_err;
  assign o_tx_empty_irq     = st_reg.irq_txe;
  assign o_tx_end_irq       = st_reg.irq_tx_end_flag;

endmodule : sprt_serial_port

`default_nettype wire

// File: tb/sprt_station.sv
// remote station: frames on the receive line, sync bits on clock falls
// assumes the bench calls its tasks; internal serial clock mode only
`timescale 1ns/1ps
`default_nettype none

module sprt_station (
  input  wire logic i_clk,  // core clock
  input  wire logic i_sck,  // device serial clock out
  output logic      o_rxd,  // device receive line
  output logic      o_sck   // external clock pin
);
  logic [15:0] sq;   // sync bits still to send, lsb first
  logic [4:0]  sn;   // count of sync bits left
  logic        sp;   // clock seen on the last edge
  logic        act;  // sync traffic has begun

  // external clock is not exercised, so the pin idles high
  assign o_sck = 1'b1;

  initial begin
    o_rxd = 1'b1;
    sn    = 5'h00;
    sp    = 1'b1;
    act   = 1'b0;
  end

  // bit changes one core cycle after the fall, well before the rise
  always @(posedge i_clk) begin
    sp <= i_sck;
    if (sp && !i_sck && sn != 5'h00) begin
      o_rxd <= sq[0];
      sq    <= sq >> 1;
      sn    <= sn - 5'h01;
    end else if (sp && !i_sck && act) begin
      // hold time over: never leave the old level for the device
      o_rxd <= ~o_rxd;
    end
  end

  task automatic load_sync(input logic [15:0] d);
    sq  = d;
    sn  = 5'h10;
    act = 1'b1;
  endtask : load_sync

  // one bit per 16 core cycles, matching a divider of zero
  task automatic send_async(input logic [7:0] d, input logic pen,
                            input logic pb, input logic stop);
    logic [10:0] f;
    f = {stop, pb, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || pen) begin
        @(posedge i_clk);
        o_rxd <= f[i];
        repeat (15) @(posedge i_clk);
      end
    end
    @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask : send_async
endmodule : sprt_station

`default_nettype wire

// File: tb/sprt_serial_port_asserts.sv
// checker of flags, requests and sync clocking at the port pins
// assumes it is bound to sprt_serial_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module sprt_port_chk (
  input wire logic       i_core_clk,           // clock
  input wire logic       i_arst_n,             // reset
  input wire logic       i_sync_mode,          // sync mode
  input wire logic       i_rx_irq_enable,      // rx req on
  input wire logic       i_tx_end_irq_enable,  // end req on
  input wire logic       i_tx_irq_enable,      // empty req on
  input wire logic       o_tx_empty_irq,       // empty req
  input wire logic       i_tx_wr,              // tx write
  input wire logic       o_txd,                // tx line
  input wire logic       o_sck,                // clock out
  input wire logic       o_sck_oe,             // clock drive
  input wire logic [7:0] o_rx_data,            // rx data
  input wire logic       o_rx_full_flag,       // rx full
  input wire logic       o_overrun_flag,       // overrun
  input wire logic       o_framing_err_flag,   // framing
  input wire logic       o_parity_err_flag,    // parity
  input wire logic       o_tx_empty_flag,      // tx empty
  input wire logic       o_tx_end_flag,        // tx end
  input wire logic       o_rx_full_irq,        // full req
  input wire logic       o_rx_error_irq,       // error req
  input wire logic       o_tx_end_irq          // end req
);
  logic err;

  assign err = o_overrun_flag || o_framing_err_flag || o_parity_err_flag;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_err_irq: assert property (
    o_rx_error_irq == ($past(i_rx_irq_enable) && err)) else $error("eri");
  a_full_irq: assert property (
    o_rx_full_irq == ($past(i_rx_irq_enable) && o_rx_full_flag))
    else $error("rxi");
  a_end_irq: assert property (
    o_tx_end_irq == ($past(i_tx_end_irq_enable) && o_tx_end_flag))
    else $error("tei");
  a_empty_irq: assert property (
    o_tx_empty_irq == ($past(i_tx_irq_enable) && o_tx_empty_flag))
    else $error("txi");
  a_ovr_lose: assert property (
    $rose(o_overrun_flag) |-> $stable(o_rx_data) && $past(o_rx_full_flag))
    else $error("overrun kept data");
  a_err_no_full: assert property (
    $rose(o_framing_err_flag) || $rose(o_parity_err_flag)
    |-> !$rose(o_rx_full_flag)) else $error("error set full");
  a_err_halt: assert property (
    err && $past(err) |-> $stable(o_rx_data)) else $error("rx ran");
  a_txd_fall: assert property (
    $changed(o_txd) && o_sck_oe && $past(o_sck_oe) |-> $fell(o_sck))
    else $error("txd moved off fall");
  a_txd_hold: assert property (
    o_tx_end_flag && $past(o_tx_end_flag) && o_sck_oe |-> $stable(o_txd))
    else $error("txd moved at end");
  a_empty_fall: assert property (
    $fell(o_tx_empty_flag) |-> $past(i_tx_wr)) else $error("empty fell");
  a_tx_block: assert property (
    $past(err) && $past(i_sync_mode) |-> !$rose(o_tx_empty_flag))
    else $error("tx began on error");

  c_overrun: cover property ($rose(o_overrun_flag));
  c_full: cover property ($rose(o_rx_full_flag));
  c_tx_end: cover property ($rose(o_tx_end_flag) && o_sck_oe);
endmodule : sprt_port_chk

bind sprt_serial_port sprt_port_chk sprt_port_chk_i (.*);

`default_nettype wire

// File: tb/sprt_serial_port_bench.sv
// bench: async frames from a row table, then a blocked and then a
// back-to-back sync transfer with receive overrun; counts mismatches
`timescale 1ns/1ps
`default_nettype none

module sprt_serial_port_bench;
  typedef struct {
    logic [7:0] d;   // frame data
    logic [4:0] c;   // parity on, odd, bad parity, stop, read after
    logic [7:0] ed;  // data register expected
    logic [3:0] ef;  // full, overrun, framing, parity expected
  } sprt_row_t;

  logic        i_core_clk, i_arst_n, i_sync_mode, i_clk_enable_hi;
  logic        i_rx_enable, i_tx_enable, i_parity_en, i_parity_odd;
  logic        i_rx_irq_enable, i_tx_irq_enable, i_tx_end_irq_enable;
  logic        i_tx_wr, i_rx_rd, i_clr_overrun, i_clr_framing;
  logic        i_clr_parity, i_clr_rx_full, i_rxd, i_sck;
  logic [15:0] i_baud_div;
  logic [7:0]  i_tx_data, o_rx_data;
  logic        o_txd, o_sck, o_sck_oe, o_rx_full_flag, o_overrun_flag;
  logic        o_framing_err_flag, o_parity_err_flag, o_tx_empty_flag;
  logic        o_tx_end_flag, o_rx_full_irq, o_rx_error_irq;
  logic        o_tx_empty_irq, o_tx_end_irq;
  int          n_mismatch, n_tests, k;
  logic [15:0] bits;
  logic [4:0]  n;
  logic        ps;
  sprt_row_t   rows [8];

  sprt_serial_port #(.DIV_W(16)) sprt_serial_port_i (.*);
  sprt_station sprt_station_i (
    .i_clk (i_core_clk),
    .i_sck (o_sck),
    .o_rxd (i_rxd),
    .o_sck (i_sck)
  );

  always #5 i_core_clk = ~i_core_clk;

  task automatic check(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // error flags by their clears, full flag by a data read
  task automatic clear_all();
    @(posedge i_core_clk);
    {i_clr_overrun, i_clr_framing, i_clr_parity, i_rx_rd} <= 4'hF;
    @(posedge i_core_clk);
    {i_clr_overrun, i_clr_framing, i_clr_parity, i_rx_rd} <= 4'h0;
  endtask : clear_all

  task automatic write_tx(input logic [7:0] d);
    @(posedge i_core_clk);
    i_tx_wr   <= 1'b1;
    i_tx_data <= d;
    @(posedge i_core_clk);
    i_tx_wr <= 1'b0;
  endtask : write_tx

  initial begin
    i_core_clk = 1'b0;
    {i_arst_n, i_sync_mode, i_clk_enable_hi, i_parity_en} = 4'h0;
    {i_parity_odd, i_tx_irq_enable, i_tx_end_irq_enable} = 3'h0;
    {i_tx_wr, i_rx_rd, i_clr_overrun, i_clr_framing} = 4'h0;
    {i_clr_parity, i_clr_rx_full} = 2'h0;
    {i_rx_enable, i_tx_enable, i_rx_irq_enable} = 3'h7;
    i_baud_div = 16'h0000;
    i_tx_data  = 8'h00;
    rows = '{
      '{8'hA5, 5'h02, 8'hA5, 4'h8},
      '{8'h3C, 5'h01, 8'hA5, 4'hE},
      '{8'h96, 5'h13, 8'h96, 4'h8},
      '{8'h69, 5'h1B, 8'h69, 4'h8},
      '{8'h0F, 5'h17, 8'h0F, 4'h1},
      '{8'hF0, 5'h01, 8'hF0, 4'h2},
      '{8'h33, 5'h1C, 8'h33, 4'h3},
      '{8'h55, 5'h02, 8'h33, 4'h3}
    };
    repeat (4) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    @(negedge i_core_clk);
    check("reset", 16'h000F, {o_rx_data, o_rx_full_flag, o_overrun_flag,
      o_framing_err_flag, o_parity_err_flag, o_tx_empty_flag,
      o_tx_end_flag, o_txd, o_sck});
    for (int r = 0; r < 8; r++) begin
      @(posedge i_core_clk);
      i_parity_en  <= rows[r].c[4];
      i_parity_odd <= rows[r].c[3];
      sprt_station_i.send_async(rows[r].d, rows[r].c[4],
        ^{rows[r].d, rows[r].c[3], rows[r].c[2]}, rows[r].c[1]);
      repeat (4) @(negedge i_core_clk);
      check("rx frame", {4'h0, rows[r].ed, rows[r].ef}, {4'h0, o_rx_data,
        o_rx_full_flag, o_overrun_flag, o_framing_err_flag,
        o_parity_err_flag});
      if (rows[r].c[0]) begin
        clear_all();
        @(negedge i_core_clk);
        check("read clear", 16'h0000, {15'h0000, o_rx_full_flag});
      end
    end
    // framing and parity errors are still set from the last rows
    @(posedge i_core_clk);
    i_sync_mode         <= 1'b1;
    i_baud_div          <= 16'h0003;
    i_tx_irq_enable     <= 1'b1;
    i_tx_end_irq_enable <= 1'b1;
    sprt_station_i.load_sync(16'h2AC5);
    write_tx(8'hB1);
    repeat (40) @(negedge i_core_clk);
    check("blocked", 16'h0001, {14'h0000, o_tx_empty_flag, o_sck});
    clear_all();
    for (k = 0; k < 100 && o_tx_empty_flag !== 1'b1; k++)
      @(negedge i_core_clk);
    if (k == 100) begin
      n_mismatch++;
      give_verdict();
    end
    write_tx(8'h4E);
    n  = 5'h00;
    ps = o_sck;
    for (k = 0; k < 400 && n < 5'h10; k++) begin
      @(negedge i_core_clk);
      if (!ps && o_sck) begin
        bits[n[3:0]] = o_txd;
        n++;
      end
      ps = o_sck;
    end
    if (k == 400) begin
      n_mismatch++;
    end
    repeat (12) @(negedge i_core_clk);
    check("tx bits", 16'h4EB1, bits);
    check("pulses", 16'h0010, {11'h000, n});
    check("tx end", 16'h0003, {13'h0000, o_txd, o_sck,
      o_tx_end_flag});
    check("sync rx", {6'h00, 8'hC5, 2'h3}, {6'h00, o_rx_data,
      o_rx_full_flag, o_overrun_flag});
    give_verdict();
  end
endmodule : sprt_serial_port_bench

`default_nettype wire
